// ### rtl/count_prescaler.sv
`timescale 1ns/1ps
// ****************************************************************
// count clock prescaler
// ****************************************************************
module count_prescaler (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick_in,
	input  wire logic       clear,
	input  wire logic [1:0] ratio_sel,
	output logic            tick_out
);

	timer_pkg::prescale_state_t s_q;
	timer_pkg::prescale_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (clear) begin
			s_d.cnt = timer_pkg::PRESCALE_RESET;
		end else if (tick_in) begin
			// R12 divide by 1 2 4 8
			if (s_q.cnt >= timer_pkg::prescale_last(ratio_sel)) begin
				s_d.cnt  = timer_pkg::PRESCALE_RESET;
				s_d.tick = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_out = s_q.tick;

endmodule : count_prescaler

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// two-stage pin synchroniser
// ****************************************************************
module pin_sync #(
	parameter int unsigned W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d    = s_q;
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.s2;

endmodule : pin_sync

// ### rtl/sixteen_bit_timer_counter.sv
`timescale 1ns/1ps
// Behaviour
// R01 - count is sixteen bits, low and high bytes, both read/write
// R02 - count climbs from zero to all ones, then wraps to zero
// R03 - wrap sets overflow flag, held until software clears it
// R04 - overflow interrupts only while overflow interrupt enable is set
// R05 - control bit 1 selects timer or counter operation
// R06 - timer operation counts every instruction cycle
// R07 - counter operation counts rising edges of external clock
// R08 - counting only while run enable is set; held otherwise
// R09 - reset input driven by either capture/compare unit
// R10 - newer parts: oscillator enable forces both oscillator pins input
// R11 - older parts: software makes low oscillator pin input itself
// R12 - two-bit prescale field selects divide by 1, 2, 4, 8
// R13 - control bit 3 runs or stops crystal oscillator
// R14 - stopped oscillator has inverter and feedback disabled
// R15 - timer clock is fosc/4; sync bit ignored there
// R16 - external clock synchronised after prescaler when sync bit clear; code always synchronises both pins before the prescaler, sync bit unused
// R17 - capture/compare reset clears both count bytes that cycle
module sixteen_bit_timer_counter #(
	parameter bit LEGACY_PIN_MODE = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_count_pin,
	input  wire logic        crystal_input_pin,
	input  wire logic        capture_compare_unit_one_reset,
	input  wire logic        capture_compare_unit_two_reset,
	output logic             overflow_irq,
	output logic             crystal_oscillator_run,
	output logic             crystal_feedback_enable,
	output logic             oscillator_pin_low_oe,
	output logic             oscillator_pin_high_oe
);

	// ************************************************************
	// state and local nets
	// ************************************************************
	timer_pkg::timer_state_t s_q;
	timer_pkg::timer_state_t s_d;

	logic [1:0]  pins_sync;
	logic        src_level;
	logic        src_rise;
	logic        instr_tick;
	logic        count_in;
	logic        pre_tick;
	logic        pre_clear;
	logic        setup_ph;
	logic        access_ph;
	logic        wr_en;
	logic        cc_reset;
	logic        overflow;
	logic        run;
	logic        osc_en;
	logic [1:0]  ps_sel;
	logic        hit_ctrl;
	logic        hit_low;
	logic        hit_high;
	logic        hit_flag;
	logic        hit_ie;
	logic        hit_dir;
	logic        wr_ctrl;
	logic        wr_low;
	logic        wr_high;
	logic        wr_ie;
	logic        wr_dir;
	logic        clr_flag;
	logic        edge_seed;
	logic [15:0] count_inc;
	logic [15:0] count_next;
	logic        flag_next;
	logic        irq_next;
	logic [5:0]  ctrl_next;
	logic [1:0]  dir_next;
	logic        ie_next;
	logic        osc_next;
	logic [1:0]  oe_next;
	logic        resp_ready;
	logic        resp_err;
	logic [31:0] resp_data;

	// ************************************************************
	// external clock synchronisers
	// ************************************************************
	// R16 pins synchronised
	pin_sync #(
		.W (2)
	) u_pin_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.din   ({crystal_input_pin, external_count_pin}),
		.dout  (pins_sync)
	);

	// ************************************************************
	// prescaler
	// ************************************************************
	count_prescaler u_prescaler (
		.clk       (pclk),
		.rst_n     (presetn),
		.tick_in   (count_in),
		.clear     (pre_clear),
		.ratio_sel (ps_sel),
		.tick_out  (pre_tick)
	);

	// ************************************************************
	// read mux and decode helpers
	// ************************************************************
	function automatic logic [31:0] read_word(
		input timer_pkg::timer_state_t st,
		input logic [11:0]             a
	);
		read_word = 32'h0000_0000;
		if (timer_pkg::addr_hit(a, timer_pkg::OFF_CONTROL)) begin
			read_word = {26'h000_0000, st.ctrl};
		end else if (timer_pkg::addr_hit(a, timer_pkg::OFF_COUNT_LOW)) begin
			read_word = {24'h00_0000, st.count[7:0]};
		end else if (timer_pkg::addr_hit(a, timer_pkg::OFF_COUNT_HIGH)) begin
			read_word = {24'h00_0000, st.count[15:8]};
		end else if (timer_pkg::addr_hit(a, timer_pkg::OFF_IRQ_FLAG)) begin
			read_word = {31'h0000_0000, st.flag};
		end else if (timer_pkg::addr_hit(a, timer_pkg::OFF_IRQ_ENABLE)) begin
			read_word = {31'h0000_0000, st.ie};
		end else if (timer_pkg::addr_hit(a, timer_pkg::OFF_DIRECTION)) begin
			read_word = {30'h0000_0000, st.dir};
		end
	endfunction : read_word

	function automatic logic mapped(input logic [11:0] a);
		mapped = timer_pkg::addr_hit(a, timer_pkg::OFF_CONTROL)
			| timer_pkg::addr_hit(a, timer_pkg::OFF_COUNT_LOW)
			| timer_pkg::addr_hit(a, timer_pkg::OFF_COUNT_HIGH)
			| timer_pkg::addr_hit(a, timer_pkg::OFF_IRQ_FLAG)
			| timer_pkg::addr_hit(a, timer_pkg::OFF_IRQ_ENABLE)
			| timer_pkg::addr_hit(a, timer_pkg::OFF_DIRECTION);
	endfunction : mapped

	// ************************************************************
	// control fields
	// ************************************************************
	always_comb begin
		// R08 run bit
		run    = s_q.ctrl[timer_pkg::RUN_BIT];
		// R13 oscillator enable bit
		osc_en = s_q.ctrl[timer_pkg::OSC_BIT];
		// R12 prescale field
		ps_sel = s_q.ctrl[timer_pkg::PRESCALE_LSB +: 2];
	end

	// ************************************************************
	// count clock selection
	// ************************************************************
	always_comb begin
		// R15 fosc/4 instruction tick
		instr_tick = (s_q.instr_div == timer_pkg::INSTR_DIV_LAST);
		// R07 crystal pin when oscillator runs
		src_level = osc_en ? pins_sync[1] : pins_sync[0];
		src_rise  = src_level & ~s_q.edge_prev;
		// R05 source select
		// R06 timer counts instructions
		// R08 gated by run enable
		count_in = run & (s_q.ctrl[timer_pkg::SOURCE_BIT] ? src_rise : instr_tick);
	end

	// ************************************************************
	// bus phases
	// ************************************************************
	always_comb begin
		setup_ph  = psel & ~penable;
		access_ph = psel & penable & s_q.pready;
		wr_en     = access_ph & pwrite & ~s_q.pslverr;
		// R09 either unit resets the count
		cc_reset  = capture_compare_unit_one_reset | capture_compare_unit_two_reset;
		pre_clear = cc_reset | wr_low | wr_high;
	end

	// ************************************************************
	// register decode
	// ************************************************************
	always_comb begin
		hit_ctrl = timer_pkg::addr_hit(paddr, timer_pkg::OFF_CONTROL);
		// R01 both count bytes mapped
		hit_low  = timer_pkg::addr_hit(paddr, timer_pkg::OFF_COUNT_LOW);
		hit_high = timer_pkg::addr_hit(paddr, timer_pkg::OFF_COUNT_HIGH);
		hit_flag = timer_pkg::addr_hit(paddr, timer_pkg::OFF_IRQ_FLAG);
		hit_ie   = timer_pkg::addr_hit(paddr, timer_pkg::OFF_IRQ_ENABLE);
		hit_dir  = timer_pkg::addr_hit(paddr, timer_pkg::OFF_DIRECTION);
		wr_ctrl  = wr_en & hit_ctrl;
		wr_low   = wr_en & hit_low;
		wr_high  = wr_en & hit_high;
		wr_ie    = wr_en & hit_ie;
		wr_dir   = wr_en & hit_dir;
		// R03 write one clears
		clr_flag = wr_en & hit_flag & pwdata[0];
	end

	// ************************************************************
	// bus response
	// ************************************************************
	always_comb begin
		// bus answer one cycle after setup
		resp_ready = setup_ph;
		resp_err   = setup_ph & ~mapped(paddr);
		resp_data  = s_q.prdata;
		// R01 reserved bits read zero
		if (setup_ph & ~pwrite) begin
			resp_data = read_word(s_q, paddr);
		end
	end

	// ************************************************************
	// control, enable and direction
	// ************************************************************
	always_comb begin
		ctrl_next = s_q.ctrl;
		ie_next   = s_q.ie;
		dir_next  = s_q.dir;
		if (wr_ctrl) begin
			// R05 source select stored
			// R13 oscillator enable stored with control
			ctrl_next = pwdata[timer_pkg::CONTROL_W-1:0];
		end
		if (wr_ie) begin
			ie_next = pwdata[0];
		end
		if (wr_dir) begin
			dir_next = pwdata[1:0];
		end
		// R13 oscillator run
		osc_next  = ctrl_next[timer_pkg::OSC_BIT];
		// R07 edge seed follows next source, no false edge
		edge_seed = osc_next ? pins_sync[1] : pins_sync[0];
	end

	// ************************************************************
	// count arithmetic
	// ************************************************************
	always_comb begin
		count_inc  = s_q.count + 16'h0001;
		count_next = s_q.count;
		overflow   = 1'b0;
		// R08 advance only while running
		// R06 one step per prescaled tick
		if (pre_tick & run) begin
			// R02 wrap from all ones to zero
			count_next = count_inc;
			overflow   = (s_q.count == timer_pkg::COUNT_MAX);
		end
		// R01 byte-wise count writes
		if (wr_low) begin
			count_next[7:0] = pwdata[7:0];
		end
		if (wr_high) begin
			count_next[15:8] = pwdata[7:0];
		end
		// R17 capture/compare reset wins
		if (cc_reset) begin
			count_next = timer_pkg::COUNT_RESET;
		end
	end

	// ************************************************************
	// overflow flag, interrupt and pins
	// ************************************************************
	always_comb begin
		flag_next = s_q.flag & ~clr_flag;
		// R03 sticky overflow, set beats clear
		if (overflow) begin
			flag_next = 1'b1;
		end
		// R04 interrupt gated by enable
		irq_next = flag_next & ie_next;
		// R10 oscillator forces both pins input
		// R11 legacy low pin follows direction
		oe_next[1] = ~dir_next[1] & ~osc_next;
		oe_next[0] = ~dir_next[0] & ~(osc_next & ~LEGACY_PIN_MODE);
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_d = s_q;

		// free-running instruction divider
		s_d.instr_div = instr_tick ? 2'h0 : s_q.instr_div + 2'h1;
		s_d.edge_prev = edge_seed;

		// count and registers
		s_d.count = count_next;
		s_d.ctrl  = ctrl_next;
		s_d.ie    = ie_next;
		s_d.dir   = dir_next;

		// bus answer
		s_d.pready  = resp_ready;
		s_d.pslverr = resp_err;
		s_d.prdata  = resp_data;

		// status and outputs
		s_d.flag    = flag_next;
		s_d.irq     = irq_next;
		// R14 feedback off when stopped
		s_d.osc_run = osc_next;
		s_d.pin_oe  = oe_next;
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q           <= '0;
			s_q.ctrl      <= timer_pkg::CONTROL_RESET;
			s_q.count     <= timer_pkg::COUNT_RESET;
			s_q.dir       <= timer_pkg::DIRECTION_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata                  = s_q.prdata;
	assign pready                  = s_q.pready;
	assign pslverr                 = s_q.pslverr;
	assign overflow_irq            = s_q.irq;
	assign crystal_oscillator_run  = s_q.osc_run;
	assign crystal_feedback_enable = s_q.osc_run;
	assign oscillator_pin_low_oe   = s_q.pin_oe[0];
	assign oscillator_pin_high_oe  = s_q.pin_oe[1];

endmodule : sixteen_bit_timer_counter

// ### rtl/timer_pkg.sv
// ****************************************************************
// timer package
// ****************************************************************
package timer_pkg;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam int unsigned ADDR_W          = 12;
	localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h008;
	localparam logic [11:0] OFF_IRQ_FLAG    = 12'h00c;
	localparam logic [11:0] OFF_CONTROL     = 12'h010;
	localparam logic [11:0] OFF_COUNT_LOW   = 12'h014;
	localparam logic [11:0] OFF_COUNT_HIGH  = 12'h018;
	localparam logic [11:0] OFF_DIRECTION   = 12'h01c;

	// ************************************************************
	// control field positions
	// ************************************************************
	localparam int unsigned RUN_BIT         = 0;
	localparam int unsigned SOURCE_BIT      = 1;
	localparam int unsigned SYNC_BIT        = 2;
	localparam int unsigned OSC_BIT         = 3;
	localparam int unsigned PRESCALE_LSB    = 4;
	localparam int unsigned CONTROL_W       = 6;

	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic [5:0]  CONTROL_RESET   = 6'h00;
	localparam logic [1:0]  DIRECTION_RESET = 2'h3;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [15:0] COUNT_MAX       = 16'hffff;
	localparam logic [2:0]  PRESCALE_RESET  = 3'h0;
	localparam int unsigned FOSC_PER_INSTR  = 4;
	localparam logic [1:0]  INSTR_DIV_LAST  = 2'(FOSC_PER_INSTR - 1);

	// ************************************************************
	// state carriers
	// ************************************************************
	typedef struct packed {
		logic [2:0] cnt;
		logic       tick;
	} prescale_state_t;

	typedef struct packed {
		logic [5:0]  ctrl;
		logic [15:0] count;
		logic        flag;
		logic        ie;
		logic [1:0]  dir;
		logic [1:0]  instr_div;
		logic        edge_prev;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq;
		logic        osc_run;
		logic [1:0]  pin_oe;
	} timer_state_t;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [2:0] prescale_last(input logic [1:0] sel);
		unique case (sel)
			2'h0: prescale_last = 3'h0;
			2'h1: prescale_last = 3'h1;
			2'h2: prescale_last = 3'h3;
			2'h3: prescale_last = 3'h7;
		endcase
	endfunction : prescale_last

	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
		addr_hit = (a == off);
	endfunction : addr_hit

endpackage : timer_pkg

// ### verif/clk_source.sv
`timescale 1ns/1ps
// ********************************
// external count clock source
// ********************************
module clk_source (
	input  wire logic pclk,
	output logic      ext_pin,
	output logic      xtal_pin
);
	initial begin
		ext_pin = 1'b0;
		xtal_pin = 1'b0;
	end
	task automatic pulse(input logic sel, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge pclk);
			{xtal_pin, ext_pin} <= sel ? 2'b10 : 2'b01;
			repeat (8) @(posedge pclk);
			{xtal_pin, ext_pin} <= 2'b00;
		end
	endtask : pulse
endmodule : clk_source

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [11:0] CT = timer_pkg::OFF_CONTROL;
	localparam logic [11:0] CL = timer_pkg::OFF_COUNT_LOW;
	localparam logic [11:0] CH = timer_pkg::OFF_COUNT_HIGH;
	localparam logic [11:0] FL = timer_pkg::OFF_IRQ_FLAG;
	localparam logic [11:0] EN = timer_pkg::OFF_IRQ_ENABLE;
	localparam logic [11:0] DR = timer_pkg::OFF_DIRECTION;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        irq, osc_run, fb, oe_lo, oe_hi, ext_pin, xtal_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0]  ccp;
	int          err_total, n_compared, cyc;
	sixteen_bit_timer_counter i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_pin(ext_pin), .crystal_input_pin(xtal_pin),
		.capture_compare_unit_one_reset(ccp[0]), .capture_compare_unit_two_reset(ccp[1]),
		.overflow_irq(irq), .crystal_oscillator_run(osc_run), .crystal_feedback_enable(fb),
		.oscillator_pin_low_oe(oe_lo), .oscillator_pin_high_oe(oe_hi)
	);
	clk_source i_src (.pclk(pclk), .ext_pin(ext_pin), .xtal_pin(xtal_pin));
	// ********************************
	// tasks
	// ********************************
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	task automatic settle;
		repeat (4) @(posedge pclk);
	endtask : settle
	// ********************************
	// clock, timeout, tests
	// ********************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ccp} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CT, 32'h0);
		rd(CL, 32'h0);
		rd(CH, 32'h0);
		rd(DR, 32'h3);
		rd(FL, 32'h0);
		rd(EN, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk(e, 32'h1);
		apb(1'b1, 12'h024, 32'hff);
		chk(e, 32'h1);
		$display("test reset_map finished");
		wr(CL, 32'ha5);
		wr(CH, 32'h5a);
		repeat (50) @(posedge pclk);
		rd(CL, 32'ha5);
		rd(CH, 32'h5a);
		for (int i = 0; i < 2; i++) begin
			wr(CL, 32'h34);
			wr(CH, 32'h12);
			ccp <= 2'(1 << i);
			@(posedge pclk);
			ccp <= 2'b00;
			rd(CL, 32'h0);
			rd(CH, 32'h0);
		end
		$display("test count_bytes finished");
		for (int p = 0; p < 4; p++) begin
			wr(CL, 32'h0);
			wr(CH, 32'h0);
			wr(CT, 32'((p << 4) | 5));
			repeat (32 << p) @(posedge pclk);
			wr(CT, 32'h0);
			apb(1'b0, CL, 32'h0);
			chk(r >= 6 && r <= 9, 32'h1);
		end
		$display("test prescale finished");
		wr(CL, 32'h0);
		wr(CT, 32'h03);
		i_src.pulse(1'b0, 5);
		i_src.pulse(1'b1, 2);
		repeat (10) @(posedge pclk);
		wr(CT, 32'h0);
		rd(CL, 32'h5);
		wr(CL, 32'h0);
		wr(CT, 32'h0f);
		i_src.pulse(1'b1, 3);
		i_src.pulse(1'b0, 2);
		repeat (10) @(posedge pclk);
		wr(CT, 32'h0);
		rd(CL, 32'h3);
		$display("test counter finished");
		wr(CL, 32'hff);
		wr(CH, 32'hff);
		wr(CT, 32'h01);
		repeat (12) @(posedge pclk);
		wr(CT, 32'h0);
		rd(CH, 32'h0);
		apb(1'b0, CL, 32'h0);
		chk(r <= 4, 32'h1);
		rd(FL, 32'h1);
		chk(irq, 32'h0);
		wr(FL, 32'h0);
		rd(FL, 32'h1);
		wr(EN, 32'h1);
		settle();
		chk(irq, 32'h1);
		wr(EN, 32'h0);
		settle();
		chk(irq, 32'h0);
		wr(EN, 32'h1);
		rd(FL, 32'h1);
		wr(FL, 32'h1);
		rd(FL, 32'h0);
		settle();
		chk(irq, 32'h0);
		wr(EN, 32'h0);
		$display("test overflow finished");
		wr(DR, 32'h0);
		settle();
		chk({osc_run, fb, oe_lo, oe_hi}, 32'h3);
		wr(CT, 32'h08);
		settle();
		chk({osc_run, fb, oe_lo, oe_hi}, 32'hc);
		wr(DR, 32'h1);
		rd(DR, 32'h1);
		settle();
		chk({osc_run, fb, oe_lo, oe_hi}, 32'hc);
		wr(CT, 32'hff);
		rd(CT, 32'h3f);
		wr(CT, 32'h0);
		settle();
		chk({osc_run, fb, oe_lo, oe_hi}, 32'h1);
		$display("test oscillator finished");
		report_and_stop();
	end
endmodule : tb_top

bind sixteen_bit_timer_counter timer_chk #(.LEGACY_PIN_MODE(LEGACY_PIN_MODE)) i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.overflow_irq(overflow_irq), .crystal_oscillator_run(crystal_oscillator_run),
	.crystal_feedback_enable(crystal_feedback_enable),
	.oscillator_pin_low_oe(oscillator_pin_low_oe), .oscillator_pin_high_oe(oscillator_pin_high_oe)
);

// ### verif/timer_chk.sv
`timescale 1ns/1ps
// ********************************
// bus and output checks
// ********************************
module timer_chk #(
	parameter bit LEGACY_PIN_MODE = 1'b0
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        overflow_irq,
	input wire logic        crystal_oscillator_run,
	input wire logic        crystal_feedback_enable,
	input wire logic        oscillator_pin_low_oe,
	input wire logic        oscillator_pin_high_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence wr_s(logic [11:0] a, logic b);
		psel && penable && pwrite && pready && paddr == a && b;
	endsequence
	a_ready_follows: assert property (setup_s |=> pready) else $error("no ready");
	a_ready_only: assert property (!(psel && !penable) |=> !pready) else $error("stray ready");
	a_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("bad error read");
	a_feedback_osc: assert property (crystal_feedback_enable == crystal_oscillator_run)
		else $error("feedback mismatch");
	a_osc_write: assert property (wr_s(timer_pkg::OFF_CONTROL, 1'b1)
		|-> ##2 crystal_oscillator_run == $past(pwdata[3], 2)) else $error("osc run wrong");
	a_pins_forced: assert property (crystal_oscillator_run && $past(crystal_oscillator_run)
		|-> !oscillator_pin_high_oe && (LEGACY_PIN_MODE || !oscillator_pin_low_oe))
		else $error("pin not input");
	a_mask_irq: assert property (wr_s(timer_pkg::OFF_IRQ_ENABLE, !pwdata[0])
		|-> ##2 !overflow_irq) else $error("irq not masked");
	a_clear_irq: assert property (wr_s(timer_pkg::OFF_IRQ_FLAG, pwdata[0])
		|-> ##2 !overflow_irq) else $error("irq not cleared");
endmodule : timer_chk
